/* hw/scs_pkg.sv */
// Constants, field layouts and carrier types for the system clock selector
package scs_pkg;
    localparam int DW = 16;
    localparam int AW = 3;

    // Register indices on the plain register port
    localparam logic [AW-1:0] A_CLK_DIV = 3'h0;
    localparam logic [AW-1:0] A_FB_DIV = 3'h1;
    localparam logic [AW-1:0] A_TRIM = 3'h2;
    localparam logic [AW-1:0] A_CTRL = 3'h3;

    // Field positions
    localparam int F_PLL_PRE = 0;
    localparam int F_PLL_POST = 6;
    localparam int F_FAST_POST = 8;
    localparam int F_CUR_SEL = 0;
    localparam int F_REQ_SEL = 4;
    localparam int F_REQ = 8;
    localparam int F_PRI_MODE = 9;
    localparam int F_BUSY = 12;

    // Oscillator selection codes
    localparam logic [2:0] SEL_FAST = 3'h0;
    localparam logic [2:0] SEL_FAST_PLL = 3'h1;
    localparam logic [2:0] SEL_PRI = 3'h2;
    localparam logic [2:0] SEL_PRI_PLL = 3'h3;
    localparam logic [2:0] SEL_SEC = 3'h4;
    localparam logic [2:0] SEL_SLOW = 3'h5;
    localparam logic [2:0] SEL_FAST_16 = 3'h6;
    localparam logic [2:0] SEL_FAST_DIVN = 3'h7;

    // Primary oscillator modes
    localparam logic [1:0] PM_EXT = 2'h0;
    localparam logic [1:0] PM_XTAL = 2'h1;
    localparam logic [1:0] PM_FAST_XTAL = 2'h2;
    localparam logic [1:0] PM_OFF = 2'h3;

    // Reset values
    localparam logic [2:0] RST_FAST_POST = 3'h0;
    localparam logic [1:0] RST_PLL_POST = 2'h1;
    localparam logic [4:0] RST_PLL_PRE = 5'h00;
    localparam logic [8:0] RST_PLL_MULT = 9'h030;
    localparam logic [5:0] RST_TRIM = 6'h00;

    // Divider figures
    localparam logic [8:0] FAST_DIV_BASE = 9'h002;
    localparam logic [8:0] FAST_DIV_16 = 9'h010;
    localparam logic [5:0] PLL_PRE_OFS = 6'h02;
    localparam logic [9:0] PLL_MULT_OFS = 10'h002;
    localparam logic [3:0] POST_DIV_2 = 4'h2;
    localparam logic [3:0] POST_DIV_4 = 4'h4;
    localparam logic [3:0] POST_DIV_8 = 4'h8;
    localparam logic [1:0] INSTR_DIV = 2'h2;

    typedef struct packed {
        logic [2:0] fast_post;
        logic [1:0] pll_post;
        logic [4:0] pll_pre;
    } scs_clk_div_t;

    typedef struct packed {
        logic [2:0] osc_sel;
        logic [1:0] pri_mode;
        logic blank;
    } scs_cfg_t;

    typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_ARM} scs_sw_t;
endpackage

/* hw/scs_divider.sv */
// Edge-counting divider for a level clock sampled on the system clock
module scs_divider #(
    parameter int W = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic src,
    input wire logic [W-1:0] divisor,
    output logic out
);
    logic prev;
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic edge_seen;

    assign edge_seen = src & ~prev;

    always_comb begin
        if (cnt >= divisor - W'(1)) begin
            next_cnt = '0;
        end else begin
            next_cnt = cnt + W'(1);
        end
    end

    // Count source rising edges, high for the first half of each period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev <= 1'b0;
            cnt <= '0;
            out <= 1'b0;
        end else if (ce) begin
            prev <= src;
            if (edge_seen) begin
                cnt <= next_cnt;
                out <= next_cnt < (divisor >> 1);
            end
        end
    end
endmodule

/* hw/scs_clock_select.sv */
// System clock source selection, dividers and register port
//
// What this block does
// - Offer eight clock sources: RC, RC+PLL, primary, primary+PLL, secondary, slow RC, RC/16, RC/N
// - Fast RC runs nominally at 7.37 MHz; software tunes it
// - Fast RC divided by 2 to 256, field at divisor bits 10:8
// - Primary runs crystal, high-speed crystal or external clock modes
// - Low-power RC runs at 32.768 kHz and feeds watchdog and monitor
// - Only fast RC and primary may pass through the PLL
// - Fast RC frequency follows the trim register value
// - At power-on, source comes from stored select and primary mode fields
// - Unprogrammed configuration selects the fast RC
// - Configuration fields encode twelve power-on clock modes
// - Selected clock halved gives instruction and peripheral clocks
// - Instruction clock supports up to 40 MHz
// - PLL prescaler divides by 2 to 33 from a five-bit field
// - PLL feedback multiplier comes from a nine-bit field
// - PLL postscaler divides by 2, 4 or 8 from bits 7:6
// - Trim is six-bit two's complement, zero is centre, 0.375 percent steps
//
// The implementer's own choices: the address-and-strobe port and the address map.
module scs_clock_select (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CE,
    input wire logic [scs_pkg::AW-1:0] ADDR,
    input wire logic [scs_pkg::DW-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [scs_pkg::DW-1:0] RDATA,
    input wire scs_pkg::scs_cfg_t CFG,
    input wire logic FAST_OSC,
    input wire logic PRI_OSC,
    input wire logic SEC_OSC,
    input wire logic SLOW_OSC,
    input wire logic PLL_VCO,
    output logic PLL_REF,
    output logic PLL_FB,
    output logic [5:0] FAST_TRIM,
    output logic [1:0] PRI_MODE,
    output logic SLOW_REF,
    output logic SYS_CLK,
    output logic INSTR_CLK,
    output logic PERIPH_CLK
);
    scs_pkg::scs_clk_div_t clk_div;
    scs_pkg::scs_sw_t state;
    logic [8:0] pll_mult;
    logic [5:0] trim;
    logic cfg_loaded;
    logic [2:0] cur_sel;
    logic [2:0] req_sel;
    logic [2:0] tgt_sel;
    logic [2:0] cfg_sel;
    logic [1:0] pri_mode;
    logic switch_pend;
    logic sw_done;
    logic ctrl_wr;
    logic sel_level;
    logic sys_clk;
    logic instr_clk;
    logic pll_src;
    logic pll_out;
    logic fast_div_out;
    logic [8:0] fast_divisor;
    logic [5:0] pre_divisor;
    logic [9:0] fb_divisor;
    logic [3:0] post_divisor;

    // Primary selection with the primary disabled falls back to fast RC
    function automatic logic [2:0] eff_sel(input logic [2:0] sel, input logic [1:0] mode);
        if ((sel == scs_pkg::SEL_PRI || sel == scs_pkg::SEL_PRI_PLL) && mode == scs_pkg::PM_OFF) begin
            eff_sel = scs_pkg::SEL_FAST;
        end else begin
            eff_sel = sel;
        end
    endfunction

    function automatic logic [3:0] post_div(input logic [1:0] code);
        unique case (code)
            2'h0: post_div = scs_pkg::POST_DIV_2;
            2'h1: post_div = scs_pkg::POST_DIV_4;
            2'h2: post_div = scs_pkg::POST_DIV_4;
            2'h3: post_div = scs_pkg::POST_DIV_8;
        endcase
    endfunction

    assign cfg_sel = CFG.blank ? scs_pkg::SEL_FAST : eff_sel(CFG.osc_sel, CFG.pri_mode);
    assign ctrl_wr = WR && ADDR == scs_pkg::A_CTRL && WDATA[scs_pkg::F_REQ];
    assign tgt_sel = (state == scs_pkg::SW_ARM) ? req_sel : cur_sel;
    assign sw_done = (state == scs_pkg::SW_ARM && !sel_level)
        || (state == scs_pkg::SW_RUN && switch_pend && req_sel == cur_sel);

    // Power-on source latched once after reset release
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cfg_loaded <= 1'b0;
            pri_mode <= scs_pkg::PM_OFF;
        end else if (CE && !cfg_loaded) begin
            cfg_loaded <= 1'b1;
            pri_mode <= CFG.pri_mode;
        end
    end

    // Register writes
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            clk_div.fast_post <= scs_pkg::RST_FAST_POST;
            clk_div.pll_post <= scs_pkg::RST_PLL_POST;
            clk_div.pll_pre <= scs_pkg::RST_PLL_PRE;
            pll_mult <= scs_pkg::RST_PLL_MULT;
            trim <= scs_pkg::RST_TRIM;
        end else if (CE && WR) begin
            unique case (ADDR)
                scs_pkg::A_CLK_DIV: begin
                    clk_div.fast_post <= WDATA[scs_pkg::F_FAST_POST +: 3];
                    clk_div.pll_post <= WDATA[scs_pkg::F_PLL_POST +: 2];
                    clk_div.pll_pre <= WDATA[scs_pkg::F_PLL_PRE +: 5];
                end
                scs_pkg::A_FB_DIV: begin
                    pll_mult <= WDATA[8:0];
                end
                scs_pkg::A_TRIM: begin
                    trim <= WDATA[5:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Switch request, taken only while running; set wins over clear
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            switch_pend <= 1'b0;
            req_sel <= scs_pkg::SEL_FAST;
        end else if (CE) begin
            if (sw_done) begin
                switch_pend <= 1'b0;
            end
            if (ctrl_wr && state == scs_pkg::SW_RUN) begin
                switch_pend <= 1'b1;
                req_sel <= eff_sel(WDATA[scs_pkg::F_CUR_SEL +: 3], pri_mode);
            end
        end
    end

    // Register reads, data in the following cycle
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            RDATA <= '0;
        end else if (CE) begin
            RDATA <= '0;
            if (RD) begin
                unique case (ADDR)
                    scs_pkg::A_CLK_DIV: begin
                        RDATA[scs_pkg::F_FAST_POST +: 3] <= clk_div.fast_post;
                        RDATA[scs_pkg::F_PLL_POST +: 2] <= clk_div.pll_post;
                        RDATA[scs_pkg::F_PLL_PRE +: 5] <= clk_div.pll_pre;
                    end
                    scs_pkg::A_FB_DIV: begin
                        RDATA[8:0] <= pll_mult;
                    end
                    scs_pkg::A_TRIM: begin
                        RDATA[5:0] <= trim;
                    end
                    scs_pkg::A_CTRL: begin
                        RDATA[scs_pkg::F_CUR_SEL +: 3] <= cur_sel;
                        RDATA[scs_pkg::F_REQ_SEL +: 3] <= req_sel;
                        RDATA[scs_pkg::F_REQ] <= switch_pend;
                        RDATA[scs_pkg::F_PRI_MODE +: 2] <= pri_mode;
                        RDATA[scs_pkg::F_BUSY] <= state != scs_pkg::SW_RUN;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Powers of two from divide-by-2, fixed 16 for that mode
    assign fast_divisor = (tgt_sel == scs_pkg::SEL_FAST_16) ? scs_pkg::FAST_DIV_16
        : scs_pkg::FAST_DIV_BASE << clk_div.fast_post;
    assign pre_divisor = {1'b0, clk_div.pll_pre} + scs_pkg::PLL_PRE_OFS;
    // Feedback factor from the nine-bit field
    assign fb_divisor = {1'b0, pll_mult} + scs_pkg::PLL_MULT_OFS;
    assign post_divisor = post_div(clk_div.pll_post);
    // PLL reference only from fast RC or primary
    assign pll_src = (tgt_sel == scs_pkg::SEL_FAST_PLL) ? FAST_OSC : PRI_OSC;

    scs_divider #(.W(9)) u_fast_div (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .src(FAST_OSC),
        .divisor(fast_divisor),
        .out(fast_div_out)
    );

    // Reference prescaler toward the phase detector
    scs_divider #(.W(6)) u_pll_pre (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .src(pll_src),
        .divisor(pre_divisor),
        .out(PLL_REF)
    );

    scs_divider #(.W(10)) u_pll_fb (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .src(PLL_VCO),
        .divisor(fb_divisor),
        .out(PLL_FB)
    );

    scs_divider #(.W(4)) u_pll_post (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .src(PLL_VCO),
        .divisor(post_divisor),
        .out(pll_out)
    );

    // Source mux over the eight selection codes
    always_comb begin
        unique case (tgt_sel)
            scs_pkg::SEL_FAST: sel_level = FAST_OSC;
            scs_pkg::SEL_FAST_PLL: sel_level = pll_out;
            scs_pkg::SEL_PRI: sel_level = PRI_OSC;
            scs_pkg::SEL_PRI_PLL: sel_level = pll_out;
            scs_pkg::SEL_SEC: sel_level = SEC_OSC;
            scs_pkg::SEL_SLOW: sel_level = SLOW_OSC;
            scs_pkg::SEL_FAST_16: sel_level = fast_div_out;
            scs_pkg::SEL_FAST_DIVN: sel_level = fast_div_out;
        endcase
    end

    // Drain old clock low, hold low, start on new low phase
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state <= scs_pkg::SW_RUN;
            cur_sel <= scs_pkg::SEL_FAST;
            sys_clk <= 1'b0;
        end else if (CE) begin
            if (!cfg_loaded) begin
                cur_sel <= cfg_sel;
                sys_clk <= 1'b0;
            end else begin
                unique case (state)
                    scs_pkg::SW_RUN: begin
                        sys_clk <= sel_level;
                        if (switch_pend && req_sel != cur_sel) begin
                            state <= scs_pkg::SW_DRAIN;
                        end
                    end
                    scs_pkg::SW_DRAIN: begin
                        sys_clk <= sel_level;
                        if (!sel_level) begin
                            state <= scs_pkg::SW_ARM;
                        end
                    end
                    scs_pkg::SW_ARM: begin
                        sys_clk <= 1'b0;
                        if (!sel_level) begin
                            cur_sel <= req_sel;
                            state <= scs_pkg::SW_RUN;
                        end
                    end
                endcase
            end
        end
    end

    // Halve the system clock, up to 40 MHz
    scs_divider #(.W(2)) u_instr (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .src(sys_clk),
        .divisor(scs_pkg::INSTR_DIV),
        .out(instr_clk)
    );

    // Pad-side and reference outputs
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            SLOW_REF <= 1'b0;
        end else if (CE) begin
            // Low-power RC as watchdog and monitor reference
            SLOW_REF <= SLOW_OSC;
        end
    end

    // Trim drives the oscillator, sets its frequency
    assign FAST_TRIM = trim;
    assign PRI_MODE = pri_mode;
    assign SYS_CLK = sys_clk;
    assign INSTR_CLK = instr_clk;
    assign PERIPH_CLK = instr_clk;

    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    sequence s_drain_end;
        state == scs_pkg::SW_DRAIN && CE && cfg_loaded && !sel_level;
    endsequence

    sequence s_arm_end;
        state == scs_pkg::SW_ARM && CE && !sel_level;
    endsequence

    chk_cfg_load: assert property (CE && !cfg_loaded |=> cfg_loaded && cur_sel == $past(cfg_sel))
        else $error("power-on source not latched");
    chk_blank_fast: assert property (CE && !cfg_loaded && CFG.blank |=> cur_sel == scs_pkg::SEL_FAST)
        else $error("blank configuration did not pick fast RC");
    chk_drain_low: assert property (s_drain_end |=> state == scs_pkg::SW_ARM && !SYS_CLK)
        else $error("drain did not end low");
    chk_arm_switch: assert property (s_arm_end |=> state == scs_pkg::SW_RUN && cur_sel == $past(req_sel))
        else $error("switch did not complete");
    chk_arm_quiet: assert property (state == scs_pkg::SW_ARM |-> !SYS_CLK)
        else $error("clock high while arming");
    chk_sec_direct: assert property (CE && cfg_loaded && state == scs_pkg::SW_RUN && cur_sel == scs_pkg::SEL_SEC
        |=> SYS_CLK == $past(SEC_OSC))
        else $error("secondary not fed directly");
    chk_instr_half: assert property ($changed(INSTR_CLK) |-> $past(sys_clk) && $past(CE))
        else $error("instruction clock moved without system edge");
    chk_trim_write: assert property (CE && WR && ADDR == scs_pkg::A_TRIM |=> FAST_TRIM == $past(WDATA[5:0]))
        else $error("trim write lost");
    chk_div_read: assert property (CE && RD && !WR && ADDR == scs_pkg::A_CLK_DIV
        |=> RDATA[10:8] == $past(clk_div.fast_post) && RDATA[15:11] == 5'h00)
        else $error("divisor readback wrong");
endmodule

/* dv/scs_osc_model.sv */
// Partner model: free-running oscillators at every source pin
module scs_osc_model #(
    parameter int HALF [5] = '{2, 3, 5, 7, 1}
) (
    input wire logic clk,
    input wire logic nrst,
    output logic [4:0] osc
);
    int cnt [5];

    // Primary pin driven as an external clock
    // Secondary crystal, rate scaled to bench time
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            osc <= 5'h00;
            cnt <= '{default: 0};
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (cnt[i] == HALF[i] - 1) begin
                    cnt[i] <= 0;
                    osc[i] <= ~osc[i];
                end else begin
                    cnt[i] <= cnt[i] + 1;
                end
            end
        end
    end
endmodule

/* dv/tb_scs_clock_select.sv */
// Self-checking bench for the system clock selector
module tb_scs_clock_select;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK, NRST, CE, WR, RD;
    logic [scs_pkg::AW-1:0] ADDR;
    logic [scs_pkg::DW-1:0] WDATA, RDATA;
    scs_pkg::scs_cfg_t CFG;
    logic [4:0] osc;
    logic PLL_REF, PLL_FB, SLOW_REF, SYS_CLK, INSTR_CLK, PERIPH_CLK, slow_prev;
    logic [5:0] FAST_TRIM;
    logic [1:0] PRI_MODE;
    logic [3:0] probe;
    logic [31:0] rs = 32'h9ebd;
    logic [2:0] rc_code;
    logic [1:0] pp;
    int fail_count, cmp_count, cyc, hi;

    assign probe = {PLL_FB, PLL_REF, INSTR_CLK, SYS_CLK};

    scs_osc_model i_osc (.clk(CLK), .nrst(NRST), .osc(osc));

    scs_clock_select i_dut (.CLK(CLK), .NRST(NRST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .CFG(CFG), .FAST_OSC(osc[0]), .PRI_OSC(osc[1]), .SEC_OSC(osc[2]), .SLOW_OSC(osc[3]),
        .PLL_VCO(osc[4]), .PLL_REF(PLL_REF), .PLL_FB(PLL_FB), .FAST_TRIM(FAST_TRIM), .PRI_MODE(PRI_MODE),
        .SLOW_REF(SLOW_REF), .SYS_CLK(SYS_CLK), .INSTR_CLK(INSTR_CLK), .PERIPH_CLK(PERIPH_CLK));

    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [15:0] mask(input logic [2:0] a);
        case (a)
            scs_pkg::A_CLK_DIV: return 16'h07df;
            scs_pkg::A_FB_DIV: return 16'h01ff;
            scs_pkg::A_TRIM: return 16'h003f;
            default: return 16'h0000;
        endcase
    endfunction

    function automatic int exp_per(input logic [2:0] s);
        case (s)
            3'h0: return 4;
            3'h1, 3'h3: return (pp == 2'h0) ? 4 : (pp == 2'h3) ? 16 : 8;
            3'h2: return 6;
            3'h4: return 10;
            3'h5: return 14;
            3'h6: return 64;
            default: return 4 * (2 << rc_code);
        endcase
    endfunction

    task automatic test_done;
        $display("Compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_num(input int got, input int exp, input string msg);
        cmp_count++;
        if (got != exp) begin
            fail_count++;
            $display("MISMATCH %0t %s got %0d exp %0d", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(negedge CLK);
    endtask

    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        @(negedge CLK);
        d = RDATA;
        @(negedge CLK);
        chk_val(RDATA, 16'h0000, "rdata idle");
    endtask

    task automatic sel(input logic [2:0] s);
        wr(scs_pkg::A_CTRL, {7'h00, 1'b1, 5'h00, s});
    endtask

    task automatic settle(input logic [2:0] exp);
        logic [15:0] d;
        int n;
        d = 16'hffff;
        n = 0;
        while ((d[scs_pkg::F_REQ] !== 1'b0 || d[scs_pkg::F_BUSY] !== 1'b0) && n < 600) begin
            rd(scs_pkg::A_CTRL, d);
            n++;
        end
        chk_val({13'h0, d[2:0]}, {13'h0, exp}, "current source");
    endtask

    task automatic rise(input int k);
        int n;
        n = 0;
        while (probe[k] !== 1'b0 && n < 4000) begin
            @(negedge CLK);
            n++;
        end
        while (probe[k] !== 1'b1 && n < 4000) begin
            @(negedge CLK);
            n++;
        end
    endtask

    task automatic period(input int k, input int exp);
        int t0;
        rise(k);
        rise(k);
        t0 = cyc;
        rise(k);
        chk_num(cyc - t0, exp, "period");
    endtask

    task automatic do_reset(input scs_pkg::scs_cfg_t c);
        @(posedge CLK);
        NRST <= 1'b0;
        CFG <= c;
        repeat (6) @(posedge CLK);
        chk_val({8'h0, PRI_MODE, FAST_TRIM}, {8'h0, scs_pkg::PM_OFF, 6'h00}, "reset pads");
        chk_val({12'h0, SYS_CLK, INSTR_CLK, PLL_REF, PLL_FB}, 16'h0000, "reset clocks");
        NRST <= 1'b1;
        repeat (2) @(negedge CLK);
    endtask

    always @(posedge CLK) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            test_done();
        end
    end

    always @(negedge CLK) begin
        if (NRST === 1'b1) begin
            chk_val({15'h0, SLOW_REF}, {15'h0, slow_prev}, "slow ref"); // reference delay
            chk_val({15'h0, INSTR_CLK}, {15'h0, PERIPH_CLK}, "periph clk"); // equal clocks
            if (SYS_CLK === 1'b1) begin
                hi++;
            end else begin
                if (hi > 0) chk_num(hi >= 2, 1, "short pulse"); // whole pulses
                hi = 0;
            end
        end else begin
            hi = 0;
        end
        slow_prev = osc[3];
    end

    initial begin
        scs_pkg::scs_cfg_t c;
        logic [15:0] d, v;
        logic [4:0] pre;
        logic [8:0] m;
        NRST = 1'b0;
        CE = 1'b1;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = '0;
        WDATA = '0;
        CFG = '0;
        for (int i = 0; i < 27; i++) begin
            c.osc_sel = (i == 24) ? 3'h2 : i[2:0];
            c.pri_mode = (i < 24) ? i[4:3] : (i == 26) ? 2'h1 : 2'h3;
            c.blank = (i == 25);
            do_reset(c);
            rd(scs_pkg::A_CTRL, d);
            v = {13'h0, (c.blank || (c.osc_sel == 3'h2 && c.pri_mode == 2'h3)) ? 3'h0 : c.osc_sel};
            chk_val({13'h0, d[2:0]}, v, "power-on source"); // start mode
            if (!c.blank) chk_val({14'h0, PRI_MODE}, {14'h0, c.pri_mode}, "pri mode"); // pad mode
        end
        rd(scs_pkg::A_CLK_DIV, d);
        v = {5'h0, scs_pkg::RST_FAST_POST, scs_pkg::RST_PLL_POST, 1'b0, scs_pkg::RST_PLL_PRE};
        chk_val(d, v, "divisor reset"); // divisor start
        rd(scs_pkg::A_FB_DIV, d);
        chk_val(d, {7'h0, scs_pkg::RST_PLL_MULT}, "fbd reset"); // feedback start
        for (int k = 0; k < 24; k++) begin
            rs = lfsr(rs);
            v = (k == 2) ? 16'hffe0 : (k == 10) ? 16'h001f : rs[15:0];
            if (k[2:0] != scs_pkg::A_CTRL) begin
                wr(k[2:0], v);
                rd(k[2:0], d);
                chk_val(d, v & mask(k[2:0]), "readback"); // field widths
                if (k[2:0] == scs_pkg::A_TRIM) chk_val({10'h0, FAST_TRIM}, v & 16'h003f, "trim"); // trim
            end
        end
        rc_code = 3'h0;
        pp = 2'h1;
        wr(scs_pkg::A_CLK_DIV, 16'h0040);
        for (int s = 0; s < 8; s++) begin
            sel(s[2:0]);
            settle(s[2:0]);
            period(0, exp_per(s[2:0])); // source rates
        end
        period(1, 2 * exp_per(3'h7)); // halved clock
        for (int k = 0; k < 8; k++) begin
            rc_code = k[2:0];
            wr(scs_pkg::A_CLK_DIV, {5'h0, rc_code, pp, 1'b0, 5'h00});
            period(0, exp_per(3'h7)); // power of two
        end
        sel(3'h1);
        settle(3'h1);
        for (int k = 0; k < 4; k++) begin
            rs = lfsr(rs);
            pp = k[1:0];
            pre = (k == 0) ? 5'h00 : (k == 3) ? 5'h1f : rs[4:0];
            wr(scs_pkg::A_CLK_DIV, {5'h0, rc_code, pp, 1'b0, pre});
            period(0, exp_per(3'h1)); // postscale
            period(2, 4 * (pre + 2)); // prescale
        end
        sel(3'h3);
        settle(3'h3);
        period(2, 6 * (pre + 2)); // primary into pll
        for (int k = 0; k < 3; k++) begin
            rs = lfsr(rs);
            m = (k == 0) ? 9'h000 : (k == 1) ? 9'h1ff : rs[8:0];
            wr(scs_pkg::A_FB_DIV, {7'h0, m});
            period(3, 2 * (m + 2)); // feedback factor
        end
        sel(3'h5);
        settle(3'h5);
        sel(3'h4);
        sel(3'h6);
        settle(3'h4);
        period(0, exp_per(3'h4)); // direct source
        test_done();
    end
endmodule
